/* common/nv_access_pkg.sv */
package nv_access_pkg;

    // ****************************************************************
    // Register selection and field layout
    // ****************************************************************

    // Which special register an instruction writes.
    typedef enum logic [2:0] {
        SEL_ADDR_LOW,
        SEL_ADDR_HIGH,
        SEL_DATA_LOW,
        SEL_DATA_HIGH,
        SEL_CONTROL,
        SEL_UNLOCK
    } reg_sel_e;

    // One register write from the core, one instruction cycle long.
    typedef struct packed {
        logic       we;
        reg_sel_e   sel;
        logic [7:0] wdata;
    } reg_wr_s;

    // Control byte bit positions.
    localparam int CTL_SPACE_BIT = 7;
    localparam int CTL_WRITE_ENABLE_BIT_BIT  = 2;
    localparam int CTL_WR_BIT    = 1;
    localparam int CTL_RD_BIT    = 0;

    // Widths of the program address and stored word.
    localparam int ADDR_HI_BITS = 5;
    localparam int DATA_HI_BITS = 6;
    localparam int ADDR_BITS    = 8 + ADDR_HI_BITS;
    localparam int WORD_BITS    = 8 + DATA_HI_BITS;
    localparam int MEM_DEPTH    = 1 << ADDR_BITS;

    // Unlock key bytes.
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

    // Reset values.
    localparam logic [7:0] BYTE_RST = 8'h00;

    // Code protection settings; addresses at or above the boundary are protected
    // in the partial settings.
    localparam logic [1:0] CP_ALL  = 2'h0;
    localparam logic [1:0] CP_NONE = 2'h3;
    localparam logic [ADDR_BITS-1:0] PROT_BASE = 13'h1000;

    // Instruction cycles spent by a read and by a stalled write.
    localparam int OP_CYCLES = 2;

endpackage

/* rtl/prog_word_array.sv */
`timescale 1ns/100ps

// ********************************************************************
// Program word storage
// ********************************************************************

module prog_word_array
    import nv_access_pkg::*;
(
    // Clock.
    input  wire logic                 mclk,
    // Read port, data one cycle after the request.
    input  wire logic                 rd_en,
    input  wire logic [ADDR_BITS-1:0] rd_addr,
    output logic      [WORD_BITS-1:0] rd_data,
    // Write port.
    input  wire logic                 wr_en,
    input  wire logic [ADDR_BITS-1:0] wr_addr,
    input  wire logic [WORD_BITS-1:0] wr_data
);

    // The word array; contents are undefined until written, like erased cells.
    logic [WORD_BITS-1:0] cells [MEM_DEPTH];

    // Synchronous write, so the array maps onto block memory.
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            cells[wr_addr] <= wr_data;
        end
    end

    // Registered read output.
    always_ff @(posedge mclk) begin
        if (rd_en) begin
            rd_data <= cells[rd_addr];
        end
    end

endmodule

/* rtl/program_flash_self_access.sv */
`timescale 1ns/100ps

module program_flash_self_access
    import nv_access_pkg::*;
(
    // Clock and reset; every mclk cycle is one instruction cycle.
    input  wire logic       mclk,
    input  wire logic       srst,
    // Register writes from the core.
    input  wire reg_wr_s    reg_wr,
    // Configuration levels.
    input  wire logic       write_permit_config,
    input  wire logic [1:0] code_protect,
    // Software clear of the write done flag.
    input  wire logic       done_flag_clr,
    // Register contents as the core reads them.
    output logic      [7:0] nv_addr_low,
    output logic      [7:0] nv_addr_high,
    output logic      [7:0] nv_data_low,
    output logic      [7:0] nv_data_high,
    output logic      [7:0] nv_control,
    // Core stall request and completion flag.
    output logic            cpu_stall,
    output logic            write_done_flag
);

    // ****************************************************************
    // State and storage
    // ****************************************************************

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD1,
        ST_RD2,
        ST_WR1,
        ST_WR2
    } op_state_e;

    op_state_e                state_r;      // Operation sequencer.
    logic [7:0]               addr_lo_r;    // Address low byte.
    logic [ADDR_HI_BITS-1:0]  addr_hi_r;    // Address high bits.
    logic [7:0]               data_lo_r;    // Data low byte.
    logic [DATA_HI_BITS-1:0]  data_hi_r;    // Data high bits.
    logic                     space_r;      // Program space selected.
    logic                     write_enable_bit_r;       // Writes enabled.
    logic                     rd_r;         // Read trigger.
    logic                     wr_r;         // Write trigger.
    logic [1:0]               unlock_r;     // Keys seen so far.
    logic                     stall_r;      // Core stall.
    logic                     flag_r;       // Write done flag.
    logic [WORD_BITS-1:0]     mem_rdata;    // Array read data.
    logic [ADDR_BITS-1:0]     word_addr;    // Full program address.
    logic                     ctl_wr;       // Control write this cycle.
    logic                     rd_go;        // Read accepted this cycle.
    logic                     wr_go;        // Write accepted this cycle.
    logic                     wr_allowed;   // Target may be programmed.
    logic                     mem_we;       // Array write strobe.

    assign word_addr = {addr_hi_r, addr_lo_r};
    assign ctl_wr    = reg_wr.we && reg_wr.sel == SEL_CONTROL;

    // A read starts only with program space selected and nothing in flight.
    assign rd_go = ctl_wr && reg_wr.wdata[CTL_RD_BIT] && space_r
                   && state_r == ST_IDLE && !rd_r && !wr_r;

    // The trigger needs write enable from an earlier instruction and the
    // key pair written in the two instructions just before.
    assign wr_go = ctl_wr && reg_wr.wdata[CTL_WR_BIT] && space_r && write_enable_bit_r
                   && unlock_r == 2'h2 && state_r == ST_IDLE && !rd_r && !rd_go;

    // Partial protection guards the upper half; full protection guards all.
    assign wr_allowed = write_permit_config && code_protect != CP_ALL
                        && (code_protect == CP_NONE || word_addr < PROT_BASE);

    assign mem_we = state_r == ST_WR2 && wr_allowed;

    // ****************************************************************
    // Word array
    // ****************************************************************

    prog_word_array u_array (
        .mclk    (mclk),
        .rd_en   (state_r == ST_RD1),
        .rd_addr (word_addr),
        .rd_data (mem_rdata),
        .wr_en   (mem_we),
        .wr_addr (word_addr),
        .wr_data ({data_hi_r, data_lo_r})
    );

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    // Reads and writes each take two instruction cycles after the trigger.
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (rd_go) begin
                        state_r <= ST_RD1;
                    end else if (wr_go) begin
                        state_r <= ST_WR1;
                    end
                end
                ST_RD1:  state_r <= ST_RD2;
                ST_RD2:  state_r <= ST_IDLE;
                ST_WR1:  state_r <= ST_WR2;
                ST_WR2:  state_r <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Unlock tracking
    // ****************************************************************

    // Any other instruction in between breaks the sequence, since every
    // cycle is an instruction; the pair is good for one instruction only.
    always_ff @(posedge mclk) begin
        if (srst) begin
            unlock_r <= 2'h0;
        end else if (reg_wr.we && reg_wr.sel == SEL_UNLOCK
                     && reg_wr.wdata == UNLOCK_KEY1) begin
            unlock_r <= 2'h1;
        end else if (reg_wr.we && reg_wr.sel == SEL_UNLOCK
                     && reg_wr.wdata == UNLOCK_KEY2 && unlock_r == 2'h1) begin
            unlock_r <= 2'h2;
        end else begin
            unlock_r <= 2'h0;
        end
    end

    // ****************************************************************
    // Address registers
    // ****************************************************************

    // Only the low five high-address bits exist; the rest read as zero.
    always_ff @(posedge mclk) begin
        if (srst) begin
            addr_lo_r <= BYTE_RST;
            addr_hi_r <= '0;
        end else if (reg_wr.we && reg_wr.sel == SEL_ADDR_LOW) begin
            addr_lo_r <= reg_wr.wdata;
        end else if (reg_wr.we && reg_wr.sel == SEL_ADDR_HIGH) begin
            addr_hi_r <= reg_wr.wdata[ADDR_HI_BITS-1:0];
        end
    end

    // ****************************************************************
    // Data registers
    // ****************************************************************

    // A completing read wins over a software write in the same cycle.
    always_ff @(posedge mclk) begin
        if (srst) begin
            data_lo_r <= BYTE_RST;
            data_hi_r <= '0;
        end else if (state_r == ST_RD2) begin
            data_lo_r <= mem_rdata[7:0];
            data_hi_r <= mem_rdata[WORD_BITS-1:8];
        end else if (reg_wr.we && reg_wr.sel == SEL_DATA_LOW) begin
            data_lo_r <= reg_wr.wdata;
        end else if (reg_wr.we && reg_wr.sel == SEL_DATA_HIGH) begin
            data_hi_r <= reg_wr.wdata[DATA_HI_BITS-1:0];
        end
    end

    // ****************************************************************
    // Control bits
    // ****************************************************************

    // Space select is frozen while an operation runs; enable is plain.
    always_ff @(posedge mclk) begin
        if (srst) begin
            space_r <= 1'b0;
            write_enable_bit_r  <= 1'b0;
        end else if (ctl_wr) begin
            write_enable_bit_r <= reg_wr.wdata[CTL_WRITE_ENABLE_BIT_BIT];
            if (state_r == ST_IDLE && !rd_r && !wr_r) begin
                space_r <= reg_wr.wdata[CTL_SPACE_BIT];
            end
        end
    end

    // Triggers are set by software only and cleared by hardware only.
    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_r <= 1'b0;
            wr_r <= 1'b0;
        end else begin
            if (rd_go) begin
                rd_r <= 1'b1;
            end else if (state_r == ST_RD2) begin
                rd_r <= 1'b0;
            end
            if (wr_go) begin
                wr_r <= 1'b1;
            end else if (state_r == ST_WR2) begin
                wr_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Stall and completion flag
    // ****************************************************************

    // Only instruction issue stops; mclk and the peripherals keep going,
    // so the core holds its fetch for the two slots and then resumes.
    always_ff @(posedge mclk) begin
        if (srst) begin
            stall_r <= 1'b0;
        end else if (wr_go) begin
            stall_r <= 1'b1;
        end else if (state_r == ST_WR2) begin
            stall_r <= 1'b0;
        end
    end

    // A completion in the same cycle as a clear keeps the flag set.
    always_ff @(posedge mclk) begin
        if (srst) begin
            flag_r <= 1'b0;
        end else if (state_r == ST_WR2) begin
            flag_r <= 1'b1;
        end else if (done_flag_clr) begin
            flag_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    assign nv_addr_low     = addr_lo_r;
    assign nv_addr_high    = {{(8-ADDR_HI_BITS){1'b0}}, addr_hi_r};
    assign nv_data_low     = data_lo_r;
    assign nv_data_high    = {{(8-DATA_HI_BITS){1'b0}}, data_hi_r};
    assign nv_control      = {space_r, 4'h0, write_enable_bit_r, wr_r, rd_r};
    assign cpu_stall       = stall_r;
    assign write_done_flag = flag_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_read_two_cycles: assert property (rd_go |=> rd_r [*2] ##1 !rd_r)
        else $error("read trigger not held for exactly two cycles");
    a_read_data_load: assert property (rd_go |-> ##3
            {data_hi_r, data_lo_r} == $past(mem_rdata))
        else $error("read data not loaded after second cycle");
    a_data_holds: assert property (state_r != ST_RD2 && !(reg_wr.we
            && (reg_wr.sel == SEL_DATA_LOW || reg_wr.sel == SEL_DATA_HIGH))
            |=> $stable(data_lo_r) && $stable(data_hi_r))
        else $error("data registers changed without cause");
    // The partial settings must also keep the upper region untouched.
    a_refused_no_write: assert property (mem_we |-> write_permit_config
            && code_protect != CP_ALL
            && (code_protect == CP_NONE || word_addr < PROT_BASE))
        else $error("protected or unpermitted word written");
    a_unlock_needed: assert property (wr_go |-> $past(unlock_r == 2'h1)
            && $past(reg_wr.wdata, 1) == UNLOCK_KEY2)
        else $error("write started without unlock pair");
    a_stall_two_slots: assert property ($rose(stall_r) |-> stall_r [*2] ##1 !stall_r)
        else $error("stall not two instruction cycles");
    // A trigger with enable still clear must neither arm nor stall, even
    // when the same instruction sets the enable bit.
    a_write_enable_bit_earlier: assert property (ctl_wr && reg_wr.wdata[CTL_WR_BIT] && !write_enable_bit_r
            && !wr_r |=> !wr_r && !stall_r)
        else $error("write trigger accepted without prior enable");
    a_write_done: assert property (wr_go |-> ##3 !wr_r && flag_r && !stall_r)
        else $error("write completion did not clear trigger and set flag");

    c_read_done: cover property (rd_go ##3 !rd_r);
    c_write_done: cover property (wr_go && wr_allowed ##2 mem_we);
    c_write_refused: cover property (wr_go ##2 (state_r == ST_WR2 && !wr_allowed));
    c_set_beats_clear: cover property (state_r == ST_WR2 && done_flag_clr);

endmodule

/* dv/testbench.sv */
`timescale 1ns/100ps

// ********************************************************************
// Self-checking bench for the program word access block
// ********************************************************************

module testbench
    import nv_access_pkg::*;
();

    // Clock, reset and stimulus driven by the bench.
    logic       mclk                = 1'b0;
    logic       srst                = 1'b1;
    reg_wr_s    reg_wr              = '{we: 1'b0, sel: SEL_ADDR_LOW, wdata: 8'h00};
    logic       write_permit_config = 1'b1;
    logic [1:0] code_protect        = 2'h3;
    logic       done_flag_clr       = 1'b0;
    // Observed register contents and status.
    logic [7:0] nv_addr_low;
    logic [7:0] nv_addr_high;
    logic [7:0] nv_data_low;
    logic [7:0] nv_data_high;
    logic [7:0] nv_control;
    logic       cpu_stall;
    logic       write_done_flag;
    // Scoreboard counters.
    int         mismatches          = 0;
    int         checks              = 0;

    // One half period of the 100 ns instruction clock.
    always #50 mclk = ~mclk;

    program_flash_self_access program_flash_self_access_i (
        .mclk                (mclk),
        .srst                (srst),
        .reg_wr              (reg_wr),
        .write_permit_config (write_permit_config),
        .code_protect        (code_protect),
        .done_flag_clr       (done_flag_clr),
        .nv_addr_low         (nv_addr_low),
        .nv_addr_high        (nv_addr_high),
        .nv_data_low         (nv_data_low),
        .nv_data_high        (nv_data_high),
        .nv_control          (nv_control),
        .cpu_stall           (cpu_stall),
        .write_done_flag     (write_done_flag)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************

    // Compares one byte; four-state equality so an unknown never passes.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Presents one register-writing instruction for the coming edge.
    task automatic put(input reg_sel_e s, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= '{we: 1'b1, sel: s, wdata: d};
    endtask

    // An idle instruction; the short delay lets the edge's updates land.
    task automatic step();
        @(posedge mclk);
        reg_wr.we     <= 1'b0;
        done_flag_clr <= 1'b0;
        #1;
    endtask

    // Changes the configuration levels at an edge, between operations only.
    task automatic cfg(input logic [1:0] cp, input logic permit);
        @(posedge mclk);
        code_protect        <= cp;
        write_permit_config <= permit;
    endtask

    // Loads the address and data registers from a 13-bit address and 14-bit word.
    task automatic load(input logic [12:0] a, input logic [13:0] w);
        put(SEL_ADDR_LOW, a[7:0]);
        put(SEL_ADDR_HIGH, {3'h0, a[12:8]});
        put(SEL_DATA_LOW, w[7:0]);
        put(SEL_DATA_HIGH, {2'h0, w[13:8]});
    endtask

    // Full unlocked write; the stall and flag behave the same whether or not
    // the array really takes the word, so refused writes reuse this task.
    task automatic prog(input logic [12:0] a, input logic [13:0] w);
        load(a, w);
        put(SEL_CONTROL, 8'h84);
        // Keys and trigger run back to back, nothing may slip in between.
        put(SEL_UNLOCK, UNLOCK_KEY1);
        put(SEL_UNLOCK, UNLOCK_KEY2);
        put(SEL_CONTROL, 8'h86);
        step();
        chk(cpu_stall, 1'b1);
        chk(nv_control, 8'h86);
        step();
        chk(cpu_stall, 1'b1);
        step();
        chk(cpu_stall, 1'b0);
        chk(nv_control, 8'h84);
        chk(write_done_flag, 1'b1);
        @(posedge mclk);
        done_flag_clr <= 1'b1;
        step();
        chk(write_done_flag, 1'b0);
    endtask

    // Reads a word after spoiling the data registers; a poke tries to clear
    // the read trigger in mid-operation, which software must not manage.
    task automatic rd(input logic [12:0] a, input logic [13:0] w, input logic poke);
        load(a, 14'h3FFF);
        put(SEL_CONTROL, 8'h80);
        put(SEL_CONTROL, 8'h81);
        step();
        chk(nv_control[0], 1'b1);
        chk(nv_addr_low, a[7:0]);
        chk(nv_addr_high, {3'h0, a[12:8]});
        if (poke) begin
            put(SEL_CONTROL, 8'h84);
            #1;
        end else begin
            step();
        end
        chk(nv_control[0], 1'b1);
        step();
        chk(nv_control[0], 1'b0);
        chk(nv_data_low, w[7:0]);
        chk(nv_data_high, {2'h0, w[13:8]});
        step();
        step();
        chk(nv_data_low, w[7:0]);
    endtask

    // A trigger that must be ignored: no stall, no flag, trigger stays clear.
    task automatic refused(input logic [7:0] c, input logic [7:0] k1, input logic [7:0] k2);
        put(SEL_CONTROL, c);
        put(SEL_UNLOCK, k1);
        put(SEL_UNLOCK, k2);
        put(SEL_CONTROL, 8'h86);
        step();
        chk(cpu_stall, 1'b0);
        chk(nv_control[1], 1'b0);
        step();
        step();
        chk(write_done_flag, 1'b0);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************

    // Cuts a hang short; the run needs only a few hundred cycles.
    initial begin
        #2000000;
        mismatches++;
        results();
    end

    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        step();
        chk(nv_control, 8'h00);
        chk(write_done_flag, 1'b0);
        chk(cpu_stall, 1'b0);
        // A read trigger without program space selected must not start.
        put(SEL_CONTROL, 8'h01);
        step();
        chk(nv_control, 8'h00);
        // Unused upper bits of the high bytes must read back as zero.
        put(SEL_ADDR_HIGH, 8'hFF);
        put(SEL_DATA_HIGH, 8'hFF);
        step();
        chk(nv_addr_high, 8'h1F);
        chk(nv_data_high, 8'h3F);
        // Permitted writes below and above the protection boundary.
        prog(13'h0123, 14'h2A5C);
        rd(13'h0123, 14'h2A5C, 1'b0);
        prog(13'h1234, 14'h15A3);
        rd(13'h1234, 14'h15A3, 1'b1);
        // Partial protection guards the upper region only.
        cfg(2'h1, 1'b1);
        prog(13'h1234, 14'h0F0F);
        rd(13'h1234, 14'h15A3, 1'b0);
        cfg(2'h2, 1'b1);
        prog(13'h0123, 14'h1111);
        rd(13'h0123, 14'h1111, 1'b0);
        // Full protection, then a cleared permit, both leave memory alone.
        cfg(2'h0, 1'b1);
        prog(13'h0123, 14'h2222);
        rd(13'h0123, 14'h1111, 1'b0);
        cfg(2'h3, 1'b0);
        prog(13'h0123, 14'h3333);
        rd(13'h0123, 14'h1111, 1'b0);
        cfg(2'h3, 1'b1);
        // Wrong keys, wrong order, and enable set in the trigger itself.
        load(13'h0123, 14'h0444);
        refused(8'h84, 8'h55, 8'h55);
        refused(8'h84, 8'hAA, 8'h55);
        refused(8'h80, 8'h55, 8'hAA);
        rd(13'h0123, 14'h1111, 1'b0);
        results();
    end

endmodule
